// ===== rtl/spi_pkg.sv
/*
 * Shared constants and types of the serial status and data path.
 * Assumes a 32-bit AHB-Lite register bus and byte-wide registers in the low lanes.
 */
package spi_pkg;
	// Register byte addresses on the bus.
	localparam logic [7:0] CONTROL_OFFSET = 8'h00;
	localparam logic [7:0] STATUS_OFFSET  = 8'h04;
	localparam logic [7:0] DATA_OFFSET    = 8'h08;

	// Status register field positions.
	localparam int DONE_BIT  = 7;
	localparam int WRITE_COLLISION_FLAG_BIT  = 6;
	localparam int MODE_FAULT_FLAG_BIT  = 4;

	// Reset values.
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET    = 8'h00;

	// Serial clock divisors for rate codes 00, 01, 10 and 11.
	localparam int DIV_CODE0 = 2;
	localparam int DIV_CODE1 = 4;
	localparam int DIV_CODE2 = 16;
	localparam int DIV_CODE3 = 32;
	localparam int HALF_W    = 5;

	// Sixteen clock edges make one byte; the last index closes it.
	localparam logic [3:0] LAST_EDGE = 4'hF;

	// HTRANS encoding bit that marks NONSEQ or SEQ.
	localparam int HTRANS_ACTIVE = 1;

	// Control register layout, bit 7 down to bit 0.
	typedef struct packed {
		logic       irq_enable_bit;
		logic       system_enable_bit;
		logic       spare;
		logic       master_select_bit;
		logic       clock_polarity_bit;
		logic       clock_phase_bit;
		logic [1:0] rate_select;
	} control_s;

	// Serial pins as seen from outside, before synchronising.
	typedef struct packed {
		logic sck;
		logic mosi;
		logic miso;
		logic ss_n;
	} pins_s;

	typedef enum logic [1:0] {LINK_IDLE, LINK_RUN, LINK_WAIT_SS} link_e;
	typedef enum logic {BUS_IDLE, BUS_DATA} bus_e;
	typedef enum logic [1:0] {SEL_NONE, SEL_CONTROL, SEL_STATUS, SEL_DATA} sel_e;
endpackage

// ===== rtl/spi_pin_sync.sv
/*
 * Two-flop synchroniser for the serial pins.
 * Assumes the pins are asynchronous to clk; only the second stage is read outside.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_pin_sync
	import spi_pkg::*;
(
	input  wire logic  clk,
	input  wire logic  rst,
	input  wire logic  ce,
	input  wire pins_s pins_raw,
	output pins_s      pins_safe
);
	typedef struct packed {
		pins_s first;
		pins_s second;
	} sync_s;

	sync_s s;
	sync_s next_s;

	// The first stage feeds only the second stage.
	always_comb begin
		next_s = s;
		if (ce) begin
			next_s.first  = pins_raw;
			next_s.second = s.first;
		end
	end

	// Pins idle with select high so that reset does not fake a selection.
	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '{first: 4'h1, second: 4'h1};
		end else begin
			s <= next_s;
		end
	end

	assign pins_safe = s.second;
endmodule
`default_nettype wire

// ===== rtl/spi_rate_divider.sv
/*
 * Half-period tick generator for the master serial clock.
 * Assumes run stays high for the whole byte; dropping it restarts the count.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_rate_divider
	import spi_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	input  wire logic       run,
	input  wire logic [1:0] rate_select,
	output logic            tick
);
	typedef struct packed {
		logic [HALF_W-1:0] count;
		logic              tick;
	} div_s;

	div_s s;
	div_s next_s;

	// Half of the divisor less one, as the last count value of one half period.
	function automatic logic [HALF_W-1:0] half_last(input logic [1:0] code);
		unique case (code)
			2'h0: half_last = HALF_W'(DIV_CODE0 / 2 - 1);
			2'h1: half_last = HALF_W'(DIV_CODE1 / 2 - 1);
			2'h2: half_last = HALF_W'(DIV_CODE2 / 2 - 1);
			2'h3: half_last = HALF_W'(DIV_CODE3 / 2 - 1);
		endcase
	endfunction

	// One tick per half period so the caller toggles the clock on each.
	always_comb begin
		next_s = s;
		if (ce) begin
			next_s.tick = 1'b0;
			if (!run) begin
				next_s.count = '0;
			end else if (s.count >= half_last(rate_select)) begin
				next_s.count = '0;
				next_s.tick  = 1'b1;
			end else begin
				next_s.count = s.count + HALF_W'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule
`default_nettype wire

// ===== rtl/spi_status_data_path.sv
/*
 * Byte-wide serial interface: control, status and data registers on AHB-Lite,
 * master clock generation and slave shifting, flags and interrupt request.
 * Assumes one AHB-Lite master, word accesses, and pins joined by a testbench
 * that resolves each pin from its output enable.
 */
`timescale 1ns/1ps
`default_nettype none
// Operation
// - master serial clock is internal clock divided by 2, 4, 16 or 32.
// - byte completion sets the done flag as master and as slave.
// - interrupt request rises when done is set and interrupts enabled.
// - done clears after status read seeing it, then data access.
// - data writes ignored while done set and status not yet read.
// - data write during transfer sets collision flag, value discarded.
// - phase zero transfer lasts from select low until select high.
// - phase one transfer starts on first active edge, ends with done.
// - collision flag clears after status read seeing it, then data access.
// - mode fault set only as master with select driven low.
// - mode fault requests interrupt, clears enable and master bits.
// - mode fault clears after status read seeing it, then control write.
// - status bits 5 and 3 to 0 read as zero.
// - only a master data write starts a byte; slave write preloads.
// - data reads return the receive buffer, loaded at byte end.
// - byte arriving while done still set is dropped.
// - data writes go straight into the shift register.
// - data shifts most significant bit first.
// - master emits exactly eight clock pulses then idles.
// - master clock idles at the polarity bit level.
module spi_status_data_path
	import spi_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ce,
	input  wire logic        hsel,
	input  wire logic [7:0]  haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        sck_in,
	output logic             sck_out,
	output logic             sck_oe,
	input  wire logic        mosi_in,
	output logic             mosi_out,
	output logic             mosi_oe,
	input  wire logic        miso_in,
	output logic             miso_out,
	output logic             miso_oe,
	input  wire logic        ss_n_in,
	input  wire logic        ss_output_mode,
	output logic             irq
);
	typedef struct packed {
		control_s   ctrl;
		logic       done;
		logic       write_collision_flag;
		logic       mode_fault_flag;
		logic       seen_done;
		logic       seen_write_collision_flag;
		logic       seen_mode_fault_flag;
		logic [7:0] shifter;
		logic [7:0] rx_buf;
		logic       rx_bit;
		logic [3:0] edges;
		link_e      link;
		logic       sck_lvl_prev;
		logic       ss_prev;
		logic       sck;
		logic       sck_oe;
		logic       data_out;
		logic       mosi_oe;
		logic       miso_oe;
		logic       irq;
		bus_e       bus;
		sel_e       sel;
		logic       wr;
		logic       hreadyout;
		logic [31:0] hrdata;
	} state_s;

	state_s s;
	state_s next_s;
	pins_s  pins;
	logic   tick;

	// Pins cross into the clock domain before anything looks at them.
	spi_pin_sync u_sync (
		.clk       (clk),
		.rst       (rst),
		.ce        (ce),
		.pins_raw  ('{sck: sck_in, mosi: mosi_in, miso: miso_in, ss_n: ss_n_in}),
		.pins_safe (pins)
	);

	// The divider only runs while a master byte is in flight.
	spi_rate_divider u_div (
		.clk         (clk),
		.rst         (rst),
		.ce          (ce),
		.run         (s.link == LINK_RUN && s.ctrl.master_select_bit),
		.rate_select (s.ctrl.rate_select),
		.tick        (tick)
	);

	// Register selection from a byte address; unmapped addresses select nothing.
	function automatic sel_e decode(input logic [7:0] addr);
		unique case (addr)
			CONTROL_OFFSET: decode = SEL_CONTROL;
			STATUS_OFFSET:  decode = SEL_STATUS;
			DATA_OFFSET:    decode = SEL_DATA;
			default:        decode = SEL_NONE;
		endcase
	endfunction

	// Status byte with unused bits tied low.
	function automatic logic [7:0] status_byte(input logic d, input logic w, input logic m);
		status_byte           = 8'h00;
		status_byte[DONE_BIT] = d;
		status_byte[WRITE_COLLISION_FLAG_BIT] = w;
		status_byte[MODE_FAULT_FLAG_BIT] = m;
	endfunction

	// Everything below shares one next-state view so a flag set in the same
	// cycle as its clear keeps the set, which would otherwise lose an event.
	always_comb begin
		logic       enabled;
		logic       master;
		logic       lead;
		logic       trail;
		logic       sck_lvl;
		logic       in_bit;
		logic       complete;
		logic       data_rd;
		logic       data_wr;
		logic       ctrl_wr;
		logic       stat_rd;
		logic       fault;
		logic [7:0] wbyte;
		enabled  = s.ctrl.system_enable_bit;
		master   = s.ctrl.master_select_bit;
		lead     = 1'b0;
		trail    = 1'b0;
		sck_lvl  = pins.sck ^ s.ctrl.clock_polarity_bit;
		// Incoming data passes the pin synchroniser, so a sample lags its pin by two
		// to three clocks. At the two fastest rates a half period is shorter than that
		// lag and the master reads stale bits; received bytes are only good at the
		// divide-by-16 and divide-by-32 rates. Every pin still gets two flip-flops,
		// because a metastable sample would be worse than a slow one.
		// Transmit data and the clock itself are not affected by this limit.
		in_bit   = master ? pins.miso : pins.mosi;
		complete = 1'b0;
		data_rd  = 1'b0;
		data_wr  = 1'b0;
		ctrl_wr  = 1'b0;
		stat_rd  = 1'b0;
		fault    = 1'b0;
		wbyte    = hwdata[7:0];
		next_s   = s;

		if (ce) begin
			// Bus data phase: one wait cycle, then the access takes effect.
			if (s.bus == BUS_DATA) begin
				next_s.bus       = BUS_IDLE;
				next_s.hreadyout = 1'b1;
				next_s.hrdata    = 32'h0000_0000;
				data_rd = s.sel == SEL_DATA && !s.wr;
				data_wr = s.sel == SEL_DATA && s.wr;
				ctrl_wr = s.sel == SEL_CONTROL && s.wr;
				stat_rd = s.sel == SEL_STATUS && !s.wr;
				if (!s.wr) begin
					unique case (s.sel)
						SEL_CONTROL: next_s.hrdata[7:0] = s.ctrl;
						SEL_STATUS:  next_s.hrdata[7:0] = status_byte(s.done, s.write_collision_flag, s.mode_fault_flag);
						SEL_DATA:    next_s.hrdata[7:0] = s.rx_buf;
						SEL_NONE:    next_s.hrdata[7:0] = 8'h00;
					endcase
				end
			end else if (hsel && htrans[HTRANS_ACTIVE] && hready) begin
				next_s.bus       = BUS_DATA;
				next_s.sel       = decode(haddr);
				next_s.wr        = hwrite;
				next_s.hreadyout = 1'b0;
			end

			// Status read arms each flag that it saw set.
			if (stat_rd) begin
				next_s.seen_done = s.done;
				next_s.seen_write_collision_flag = s.write_collision_flag;
				next_s.seen_mode_fault_flag = s.mode_fault_flag;
			end

			// Clearing sequences; later sets in this cycle override them.
			if ((data_rd || data_wr) && s.seen_done) begin
				next_s.done      = 1'b0;
				next_s.seen_done = 1'b0;
			end
			if ((data_rd || data_wr) && s.seen_write_collision_flag) begin
				next_s.write_collision_flag      = 1'b0;
				next_s.seen_write_collision_flag = 1'b0;
			end
			if (ctrl_wr) begin
				next_s.ctrl      = wbyte;
				if (s.seen_mode_fault_flag) begin
					next_s.mode_fault_flag      = 1'b0;
					next_s.seen_mode_fault_flag = 1'b0;
				end
			end

			// Data writes: locked, colliding, or loaded straight into the shifter.
			if (data_wr && !(s.done && !s.seen_done) && enabled) begin
				if (s.link != LINK_IDLE) begin
					next_s.write_collision_flag = 1'b1;
				end else begin
					next_s.shifter  = wbyte;
					next_s.data_out = wbyte[7];
					next_s.edges    = 4'h0;
					if (master) begin
						next_s.link = LINK_RUN;
					end
				end
			end

			// Edge events, from the divider as master or the pin as slave.
			if (master) begin
				if (s.link == LINK_RUN && tick) begin
					lead = !s.edges[0];
					trail = s.edges[0];
					next_s.sck = !s.sck;
				end
			end else if (enabled && !pins.ss_n) begin
				lead  = sck_lvl && !s.sck_lvl_prev;
				trail = !sck_lvl && s.sck_lvl_prev;
				if (s.link == LINK_IDLE) begin
					if (!s.ctrl.clock_phase_bit && s.ss_prev) begin
						next_s.link     = LINK_RUN;
						next_s.edges    = 4'h0;
						next_s.data_out = s.shifter[7];
					end else if (s.ctrl.clock_phase_bit && lead) begin
						next_s.link  = LINK_RUN;
						next_s.edges = 4'h0;
					end else begin
						lead = 1'b0;
					end
					trail = 1'b0;
				end
			end
			next_s.sck_lvl_prev = sck_lvl;
			next_s.ss_prev      = pins.ss_n;

			// Shift on trailing edges, sample on the edge the phase asks for.
			if (next_s.link == LINK_RUN && (lead || trail)) begin
				next_s.edges = s.link == LINK_RUN ? s.edges + 4'h1 : 4'h1;
				if (lead) begin
					next_s.rx_bit = in_bit;
					if (s.ctrl.clock_phase_bit) begin
						next_s.data_out = s.shifter[7];
					end
				end else begin
					next_s.shifter = {s.shifter[6:0],
						s.ctrl.clock_phase_bit ? in_bit : s.rx_bit};
					if (!s.ctrl.clock_phase_bit) begin
						next_s.data_out = s.shifter[6];
					end
					complete = s.edges == LAST_EDGE;
				end
			end

			// A finished byte sets done and, unless it overruns, fills the buffer.
			if (complete) begin
				next_s.done = 1'b1;
				if (!s.done) begin
					next_s.rx_buf = next_s.shifter;
				end
				next_s.link = (!master && !s.ctrl.clock_phase_bit) ? LINK_WAIT_SS
					: LINK_IDLE;
				next_s.edges = 4'h0;
			end

			// Phase zero slave byte ends with select high; a dropped select aborts.
			if (!master && pins.ss_n && s.link != LINK_IDLE) begin
				next_s.link = LINK_IDLE;
			end

			// Another master pulling select low takes the bus away from us.
			fault = enabled && master && !ss_output_mode && !pins.ss_n;
			if (fault) begin
				next_s.mode_fault_flag                   = 1'b1;
				next_s.ctrl.system_enable_bit = 1'b0;
				next_s.ctrl.master_select_bit = 1'b0;
				next_s.link                   = LINK_IDLE;
			end
			if (!next_s.ctrl.system_enable_bit) begin
				next_s.link = LINK_IDLE;
			end

			// Clock idles at polarity whenever no master byte is running.
			if (next_s.link != LINK_RUN || !next_s.ctrl.master_select_bit) begin
				next_s.sck = next_s.ctrl.clock_polarity_bit;
			end
			next_s.sck_oe  = next_s.ctrl.system_enable_bit && next_s.ctrl.master_select_bit;
			next_s.mosi_oe = next_s.sck_oe;
			next_s.miso_oe = next_s.ctrl.system_enable_bit && !next_s.ctrl.master_select_bit
				&& !pins.ss_n;

			// Interrupt follows the done and mode fault flags, so it drops once they are cleared.
			next_s.irq = next_s.ctrl.irq_enable_bit && (next_s.done || next_s.mode_fault_flag);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			s <= '{ctrl: CONTROL_RESET, shifter: BYTE_RESET, rx_buf: BYTE_RESET,
				link: LINK_IDLE, bus: BUS_IDLE, sel: SEL_NONE, ss_prev: 1'b1,
				hreadyout: 1'b1, hrdata: 32'h0000_0000, default: 1'b0};
		end else begin
			s <= next_s;
		end
	end

	// All outputs but hresp, which is tied low, come straight from the state register.
	assign hreadyout = s.hreadyout;
	assign hresp     = 1'b0;
	assign hrdata    = s.hrdata;
	assign sck_out   = s.sck;
	assign sck_oe    = s.sck_oe;
	assign mosi_out  = s.data_out;
	assign mosi_oe   = s.mosi_oe;
	assign miso_out  = s.data_out;
	assign miso_oe   = s.miso_oe;
	assign irq       = s.irq;
endmodule
`default_nettype wire

// ===== testbench/spi_status_data_path_monitor.sv
/*
 * Checker on the ports of the serial status and data block.
 * Assumes the clock enable is high whenever bus transfers are judged.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_status_data_path_monitor
	import spi_pkg::*;
(
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        ce,
	input wire logic        hsel,
	input wire logic [7:0]  haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata,
	input wire logic        sck_out,
	input wire logic        sck_oe,
	input wire logic        miso_oe,
	input wire logic        ss_n_in,
	input wire logic        ss_output_mode
);
	logic       taken;
	logic       sck_q;
	logic [4:0] edge_cnt;
	assign taken = ce && hsel && htrans[1] && hready;
	// Counts clock toggles since the last data write; a stray extra pulse shows as 17.
	always_ff @(posedge clk) begin
		sck_q <= sck_out;
		if (rst || (taken && hwrite && haddr == DATA_OFFSET)) begin
			edge_cnt <= 5'h00;
		end else if (sck_oe && sck_out != sck_q && edge_cnt != 5'h1F) begin
			edge_cnt <= edge_cnt + 5'h01;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	bus_okay_a: assert property (hresp == 1'b0) else $error("bus response not okay");
	bus_wait_a: assert property (taken |-> ##1 !hreadyout ##1 hreadyout)
		else $error("bus wait state wrong");
	status_spare_a: assert property (
		taken && !hwrite && haddr == STATUS_OFFSET |-> ##2 hrdata[5] == 1'b0 && hrdata[3:0] == 4'h0)
		else $error("status spare bits not zero");
	upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h000000)
		else $error("upper read lanes not zero");
	rdata_hold_a: assert property ($changed(hrdata) |-> $past(hreadyout) == 1'b0)
		else $error("read data changed outside a transfer");
	fault_drop_a: assert property (
		sck_oe && !ss_n_in && !ss_output_mode |-> ##[1:8] !sck_oe)
		else $error("master kept driving after select fault");
	role_excl_a: assert property (miso_oe |-> !sck_oe)
		else $error("master and slave drivers both on");
	pulse_cap_a: assert property (edge_cnt <= 5'h10)
		else $error("more than eight clock pulses");
endmodule
bind spi_status_data_path spi_status_data_path_monitor spi_status_data_path_monitor_inst (.*);
`default_nettype wire

// ===== testbench/spi_far_slave.sv
/*
 * Far-side serial slave in clock mode zero.
 * Assumes the bench lowers select before each byte and raises it after.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_far_slave (
	input wire logic       sck,
	input wire logic       mosi,
	input wire logic       sel_n,
	input wire logic [7:0] tx_byte,
	output logic           miso,
	output logic [7:0]     rx_byte
);
	logic [7:0] sh = 8'h00;
	initial rx_byte = 8'h00;
	// Load on select, sample on rising clock, shift on falling clock, top bit first.
	always @(negedge sel_n) sh = tx_byte;
	always @(posedge sck) if (!sel_n) rx_byte = {rx_byte[6:0], mosi};
	always @(negedge sck) if (!sel_n) sh = {sh[6:0], ~sh[7]};
	// Deselected, the line shows the inverse so a stale bit cannot pass.
	assign miso = sel_n ? ~sh[7] : sh[7];
endmodule
`default_nettype wire

// ===== testbench/spi_status_data_path_tb.sv
/*
 * Self-checking bench of the serial status and data block.
 * Assumes a far slave model on the pins and the bench as sole bus master.
 */
`timescale 1ns/1ps
`default_nettype none
module spi_status_data_path_tb;
	import spi_pkg::*;
	logic clk = 0, rst = 1, ce = 1, hsel = 0, hwrite = 0, hready, hreadyout, hresp, irq;
	logic [7:0] haddr = 0, tx = 8'hC3, rx;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] hwdata = 0, hrdata;
	logic sck_in, sck_out, sck_oe, mosi_in, mosi_out, mosi_oe, miso_in, miso_out, miso_oe;
	logic ss_n_in = 1, ss_output_mode = 0, sel_n = 1, far_miso, far_sck = 0, far_mosi = 1;
	int error_cnt = 0, check_count = 0;
	// Pins resolve from enables; the bench plays far master on clock and data when the block
	// does not drive them, and those lines idle low and high.
	assign hready = hreadyout;
	assign sck_in = sck_oe ? sck_out : far_sck;
	assign mosi_in = mosi_oe ? mosi_out : far_mosi;
	assign miso_in = miso_oe ? miso_out : far_miso;
	always #25 clk = ~clk;
	spi_status_data_path spi_status_data_path_inst (.*);
	spi_far_slave spi_far_slave_inst (.sck(sck_in), .mosi(mosi_in), .sel_n(sel_n),
		.tx_byte(tx), .miso(far_miso), .rx_byte(rx));
	task automatic conclude();
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("FAIL %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
		output logic [7:0] r);
		int n;
		n = 0;
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= w;
		do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h000000, d};
		do begin @(posedge clk); n++; end while (hreadyout !== 1'b1 && n < 50);
		r = hrdata[7:0];
		if (n >= 50) chk(8'h00, 8'hFF);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [7:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] r;
		bus(1'b0, a, 8'h00, r);
		chk(r, exp);
	endtask
	// Runs until the interrupt, counting rising clock edges and their spacing.
	task automatic wait_done(output int edges, output int gap);
		int n, t1;
		logic p;
		edges = 0;
		gap = 0;
		t1 = 0;
		p = sck_out;
		for (n = 0; n < 3000 && irq !== 1'b1; n++) begin
			@(posedge clk);
			if (sck_out === 1'b1 && p === 1'b0) begin
				edges++;
				if (edges == 1) t1 = n;
				if (edges == 2) gap = n - t1;
			end
			p = sck_out;
		end
		chk({7'h00, irq}, 8'h01);
		chk({7'h00, sck_out}, 8'h00);
	endtask
	task automatic t_reset();
		rd(STATUS_OFFSET, 8'h00);
		rd(CONTROL_OFFSET, CONTROL_RESET);
		rd(8'h0C, 8'h00);
	endtask
	// Every rate code: eight pulses at the listed divisor, data out; data in checked at codes 10 and 11 only.
	task automatic t_rates();
		int dv[4] = '{DIV_CODE0, DIV_CODE1, DIV_CODE2, DIV_CODE3};
		int e, g;
		logic [7:0] r;
		for (int c = 0; c < 4; c++) begin
			wr(CONTROL_OFFSET, 8'hD0 | c[7:0]);
			sel_n <= 1'b0;
			wr(DATA_OFFSET, 8'h5A);
			wait_done(e, g);
			sel_n <= 1'b1;
			chk(e[7:0], 8'h08);
			chk(g[7:0], dv[c][7:0]);
			chk(rx, 8'h5A);
			rd(STATUS_OFFSET, 8'h80);
			if (c >= 2) rd(DATA_OFFSET, 8'hC3);
			else bus(1'b0, DATA_OFFSET, 8'h00, r);
			rd(STATUS_OFFSET, 8'h00);
		end
	endtask
	// A write mid-byte is lost; a write before the status read is ignored.
	task automatic t_collide();
		int e, g;
		sel_n <= 1'b0;
		wr(DATA_OFFSET, 8'h96);
		wr(DATA_OFFSET, 8'h11);
		wait_done(e, g);
		sel_n <= 1'b1;
		chk(rx, 8'h96);
		wr(DATA_OFFSET, 8'h22);
		g = 0;
		repeat (40) begin
			@(posedge clk);
			if (sck_out !== 1'b0) g++;
		end
		chk(g[7:0], 8'h00);
		wait_done(e, g);
		chk(e[7:0], 8'h00);
		rd(STATUS_OFFSET, 8'hC0);
		rd(DATA_OFFSET, 8'hC3);
		rd(STATUS_OFFSET, 8'h00);
	endtask
	task automatic t_fault();
		ss_output_mode <= 1'b1;
		ss_n_in <= 1'b0;
		repeat (10) @(posedge clk);
		rd(STATUS_OFFSET, 8'h00);
		ss_output_mode <= 1'b0;
		repeat (10) @(posedge clk);
		chk({7'h00, irq}, 8'h01);
		rd(CONTROL_OFFSET, 8'h83);
		rd(STATUS_OFFSET, 8'h10);
		ss_n_in <= 1'b1;
		repeat (6) @(posedge clk);
		wr(CONTROL_OFFSET, 8'hD3);
		rd(STATUS_OFFSET, 8'h00);
		chk({7'h00, irq}, 8'h00);
	endtask
	// Bench as far master in mode zero: two bytes with select high between, the second overruns.
	task automatic t_slave();
		logic [7:0] m, got;
		wr(CONTROL_OFFSET, 8'hC0);
		wr(DATA_OFFSET, 8'hA5);
		repeat (40) @(posedge clk);
		rd(STATUS_OFFSET, 8'h00);
		for (int b = 0; b < 2; b++) begin
			m = b ? 8'h81 : 8'h3C;
			got = 8'h00;
			ss_n_in <= 1'b0;
			for (int i = 7; i >= 0; i--) begin
				far_mosi <= m[i];
				repeat (8) @(posedge clk);
				got = {got[6:0], miso_in};
				far_sck <= 1'b1;
				repeat (8) @(posedge clk);
				far_sck <= 1'b0;
			end
			repeat (8) @(posedge clk);
			chk(got, b ? 8'h3C : 8'hA5);
			chk({7'h00, irq}, 8'h01);
			ss_n_in <= 1'b1;
			repeat (8) @(posedge clk);
		end
		rd(STATUS_OFFSET, 8'h80);
		rd(DATA_OFFSET, 8'h3C);
		rd(STATUS_OFFSET, 8'h00);
	endtask
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_reset();
		t_rates();
		t_collide();
		t_fault();
		t_slave();
		conclude();
	end
	// Whole run needs little more than a thousand cycles; twenty thousand means a hang.
	initial begin
		#1000000;
		error_cnt++;
		conclude();
	end
endmodule
`default_nettype wire
